// ===== core/wheel_decoder_defs.svh
// register indices, field positions, reset values and timing figures of the wheel decoder
// assumes a 32-bit word bus where byte address equals four times the register index
`ifndef WHEEL_DECODER_DEFS_SVH
`define WHEEL_DECODER_DEFS_SVH

`define WD_CORE_CLK_HZ 50000000
`define WD_SLOW_CLK_HZ 32000
`define WD_SLOW_DIV (`WD_CORE_CLK_HZ / `WD_SLOW_CLK_HZ)

`define WD_IDX_SNAPSHOT 8'hd0
`define WD_IDX_CFG 8'hd1
`define WD_IDX_PIN_A 8'hd2
`define WD_IDX_PIN_B 8'hd3
`define WD_IDX_MODE 8'hd7
`define WD_IDX_LOAD 8'hd8
`define WD_IDX_SYSRST 8'h60

`define WD_CFG_FILT_MSB 2
`define WD_CFG_FILT_LSB 0
`define WD_CFG_POL_BIT 4
`define WD_CFG_SHUTTLE_BIT 5
`define WD_SEL_MSB 2
`define WD_MODE_DOUBLE_BIT 0
`define WD_LOAD_BIT 0
`define WD_SYSRST_DEC_BIT 5

`define WD_RST_FILT 3'h0
`define WD_RST_PIN_A 3'h0
`define WD_RST_PIN_B 3'h1
`define WD_RST_DOUBLE 1'b1
`define WD_RST_SNAPSHOT 8'h00

`define WD_JITTER_PERIODS 3
`define WD_SAMPLES_PER_PERIOD 2

`endif

// ===== core/wheel_decoder_pkg.sv
// types shared by the wheel decoder files
// assumes the port banks deliver levels synchronous to core_clk
package wheel_decoder_pkg;

    typedef struct packed {
        logic [7:0] pd;
        logic [7:0] pc;
        logic [7:0] pb;
        logic [7:0] pa;
    } pad_bank_type;

    typedef struct packed {
        logic shuttle;
        logic polarity;
        logic [2:0] filter;
    } decoder_cfg_type;

endpackage

// ===== core/phase_filter.sv
// debounce filter for one normalised phase input
// assumes raw is synchronous to core_clk and sample_en is a one-cycle pulse
`timescale 1ns/1ps
module phase_filter #(
    parameter int SAMPLES = 6
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sample_en,
    input wire logic raw,
    output logic level,
    output logic rise,
    output logic fall
);

    logic sample_r;
    logic level_r;
    logic rise_r;
    logic fall_r;
    logic [3:0] stable_r;

    assign level = level_r;
    assign rise = rise_r;
    assign fall = fall_r;

    always_ff @(posedge core_clk)
    begin
        if (reset)
            sample_r <= 1'b0;
        else if (sample_en)
            sample_r <= raw;
    end

    // accept only a level held for the whole window
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            stable_r <= 4'h0;
            level_r <= 1'b0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end
        else
        begin
            rise_r <= 1'b0;
            fall_r <= 1'b0;
            if (sample_en)
            begin
                if (sample_r == level_r)
                    stable_r <= 4'h0;
                // shorter than three scaled periods is jitter
                else if (stable_r == 4'(SAMPLES - 1))
                begin
                    stable_r <= 4'h0;
                    level_r <= sample_r;
                    rise_r <= sample_r;
                    fall_r <= ~sample_r;
                end
                else
                    stable_r <= stable_r + 4'h1;
            end
        end
    end

endmodule

// ===== core/quadrature_wheel_decoder.sv
// two-phase wheel decoder with register slave on Avalon-MM
// assumes phase pins are configured as inputs and levels are synchronous to core_clk
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "wheel_decoder_defs.svh"

// Summary of operation
// - each phase picks one of eight pins by its own 3-bit selector
// - common mode steps once when both phases show the matching edge
// - double accuracy mode steps on every phase edge that does not coincide with an edge on the other phase
// - internal counter is hidden; snapshot never follows it on its own
// - writing one to the load bit copies the counter into the snapshot
// - the decoder reset bit clears the internal counter
// - filter field sets the debounce window; shorter pulses are ignored
// - a configuration bit sets the idle polarity of the phases
// - shuttle mode counts non-overlapping phase pulses
// - decoder timing runs from the 32 kHz rate
// - levels shorter than three scaled periods count as jitter
// - phases are sampled at the 32 kHz rate divided by two to n
// - reading the snapshot clears it
// - load bit clears itself when the copy is done
// - polarity zero means idle low, one means idle high
module quadrature_wheel_decoder #(
    parameter int SLOW_DIV = `WD_SLOW_DIV,
    parameter int COUNT_W = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire wheel_decoder_pkg::pad_bank_type pads,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest
);
    import wheel_decoder_pkg::*;

    localparam int SAMPLES = `WD_JITTER_PERIODS * `WD_SAMPLES_PER_PERIOD;

    decoder_cfg_type cfg_r;
    logic [2:0] pin_a_sel_r;
    logic [2:0] pin_b_sel_r;
    logic double_r;
    logic load_pend_r;
    logic dec_rst_r;
    logic [COUNT_W-1:0] counter_r;
    logic [COUNT_W-1:0] snapshot_r;
    logic [31:0] readdata_r;
    logic waitrequest_r;
    logic [10:0] slow_cnt_r;
    logic slow_tick_r;
    logic [7:0] pre_cnt_r;
    logic [7:0] pre_mask;
    logic sample_en;
    logic [7:0] index;
    logic req;
    logic rd_accept;
    logic wr_accept;
    logic [1:0] phase_raw;
    logic [1:0] lvl;
    logic [1:0] rise;
    logic [1:0] fall;
    logic a_edge;
    logic b_edge;
    logic step_up;
    logic step_dn;
    logic [31:0] read_value;

    assign readdata = readdata_r;
    assign waitrequest = waitrequest_r;
    assign index = address[9:2];
    assign req = read | write;
    assign rd_accept = read & ~waitrequest_r;
    assign wr_accept = write & ~waitrequest_r & byteenable[0];

    function automatic logic pick_pin(input pad_bank_type bank, input logic [2:0] sel);
        logic bit_v;
        bit_v = 1'b0;
        case (sel)
            3'h0: bit_v = bank.pa[2];
            3'h1: bit_v = bank.pa[3];
            3'h2: bit_v = bank.pb[6];
            3'h3: bit_v = bank.pb[7];
            3'h4: bit_v = bank.pc[2];
            3'h5: bit_v = bank.pc[3];
            3'h6: bit_v = bank.pd[6];
            default: bit_v = bank.pd[7];
        endcase
        return bit_v;
    endfunction

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            slow_cnt_r <= 11'h000;
            slow_tick_r <= 1'b0;
        end
        else if (slow_cnt_r == 11'(SLOW_DIV - 1))
        begin
            slow_cnt_r <= 11'h000;
            slow_tick_r <= 1'b1;
        end
        else
        begin
            slow_cnt_r <= slow_cnt_r + 11'h001;
            slow_tick_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            pre_cnt_r <= 8'h00;
        else if (slow_tick_r)
            pre_cnt_r <= pre_cnt_r + 8'h01;
    end

    // divide by two to the filter field
    assign pre_mask = 8'((9'h001 << cfg_r.filter) - 9'h001);
    assign sample_en = slow_tick_r & ((pre_cnt_r & pre_mask) == 8'h00);

    // normalise inputs so idle reads low
    assign phase_raw[0] = pick_pin(pads, pin_a_sel_r) ^ cfg_r.polarity;
    assign phase_raw[1] = pick_pin(pads, pin_b_sel_r) ^ cfg_r.polarity;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_phase
            phase_filter #(
                .SAMPLES(SAMPLES)
            ) u_filter (
                .core_clk(core_clk),
                .reset(reset),
                .sample_en(sample_en),
                .raw(phase_raw[g]),
                .level(lvl[g]),
                .rise(rise[g]),
                .fall(fall[g])
            );
        end
    endgenerate

    assign a_edge = rise[0] | fall[0];
    assign b_edge = rise[1] | fall[1];

    // direction decode; simultaneous edges on both phases are ignored
    always_comb
    begin
        step_up = 1'b0;
        step_dn = 1'b0;
        if (a_edge != b_edge)
        begin
            // non-overlapping pulses: phase a counts up, phase b down
            if (cfg_r.shuttle)
            begin
                step_up = double_r ? a_edge : rise[0];
                step_dn = double_r ? b_edge : rise[1];
            end
            else if (double_r)
            begin
                step_up = (a_edge & (lvl[0] != lvl[1])) | (b_edge & (lvl[0] == lvl[1]));
                step_dn = (a_edge & (lvl[0] == lvl[1])) | (b_edge & (lvl[0] != lvl[1]));
            end
            // step only when the second phase matches the first
            else
            begin
                step_up = b_edge & (lvl[0] == lvl[1]);
                step_dn = a_edge & (lvl[0] == lvl[1]);
            end
        end
    end

    // reset bit clears; wraps in two's complement
    always_ff @(posedge core_clk)
    begin
        if (reset || dec_rst_r)
            counter_r <= '0;
        else if (step_up)
            counter_r <= counter_r + COUNT_W'(1);
        else if (step_dn)
            counter_r <= counter_r - COUNT_W'(1);
    end

    // snapshot loads on command, clears on read, load wins
    always_ff @(posedge core_clk)
    begin
        if (reset)
            snapshot_r <= `WD_RST_SNAPSHOT;
        else if (load_pend_r)
            snapshot_r <= counter_r;
        else if (rd_accept && index == `WD_IDX_SNAPSHOT)
            snapshot_r <= '0;
    end

    // load bit clears once the copy is done
    always_ff @(posedge core_clk)
    begin
        if (reset)
            load_pend_r <= 1'b0;
        else if (wr_accept && index == `WD_IDX_LOAD && writedata[`WD_LOAD_BIT])
            load_pend_r <= 1'b1;
        else
            load_pend_r <= 1'b0;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cfg_r <= '{shuttle: 1'b0, polarity: 1'b0, filter: `WD_RST_FILT};
            pin_a_sel_r <= `WD_RST_PIN_A;
            pin_b_sel_r <= `WD_RST_PIN_B;
            double_r <= `WD_RST_DOUBLE;
            dec_rst_r <= 1'b0;
        end
        else if (wr_accept)
        begin
            if (index == `WD_IDX_CFG)
            begin
                cfg_r.filter <= writedata[`WD_CFG_FILT_MSB:`WD_CFG_FILT_LSB];
                cfg_r.polarity <= writedata[`WD_CFG_POL_BIT];
                cfg_r.shuttle <= writedata[`WD_CFG_SHUTTLE_BIT];
            end
            else if (index == `WD_IDX_PIN_A)
                pin_a_sel_r <= writedata[`WD_SEL_MSB:0];
            else if (index == `WD_IDX_PIN_B)
                pin_b_sel_r <= writedata[`WD_SEL_MSB:0];
            else if (index == `WD_IDX_MODE)
                double_r <= writedata[`WD_MODE_DOUBLE_BIT];
            else if (index == `WD_IDX_SYSRST)
                dec_rst_r <= writedata[`WD_SYSRST_DEC_BIT];
        end
    end

    // read mux; unmapped indices read zero
    always_comb
    begin
        read_value = 32'h0000_0000;
        if (index == `WD_IDX_SNAPSHOT)
            read_value[COUNT_W-1:0] = snapshot_r;
        else if (index == `WD_IDX_CFG)
        begin
            read_value[`WD_CFG_FILT_MSB:`WD_CFG_FILT_LSB] = cfg_r.filter;
            read_value[`WD_CFG_POL_BIT] = cfg_r.polarity;
            read_value[`WD_CFG_SHUTTLE_BIT] = cfg_r.shuttle;
        end
        else if (index == `WD_IDX_PIN_A)
            read_value[`WD_SEL_MSB:0] = pin_a_sel_r;
        else if (index == `WD_IDX_PIN_B)
            read_value[`WD_SEL_MSB:0] = pin_b_sel_r;
        else if (index == `WD_IDX_MODE)
            read_value[`WD_MODE_DOUBLE_BIT] = double_r;
        else if (index == `WD_IDX_LOAD)
            read_value[`WD_LOAD_BIT] = load_pend_r;
        else if (index == `WD_IDX_SYSRST)
            read_value[`WD_SYSRST_DEC_BIT] = dec_rst_r;
    end

    // bus handshake: answer one cycle after the request
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            waitrequest_r <= 1'b1;
            readdata_r <= 32'h0000_0000;
        end
        else if (req && waitrequest_r)
        begin
            waitrequest_r <= 1'b0;
            readdata_r <= read ? read_value : 32'h0000_0000;
        end
        else
            waitrequest_r <= 1'b1;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    a_load_copy: assert property (load_pend_r |=> snapshot_r == $past(counter_r))
        else $error("snapshot did not take counter on load");
    a_load_selfclear: assert property (load_pend_r |=> !load_pend_r)
        else $error("load bit did not clear");
    a_dec_reset: assert property (dec_rst_r |=> counter_r == '0)
        else $error("counter not cleared by decoder reset");
    a_read_clear: assert property (rd_accept && index == `WD_IDX_SNAPSHOT && !load_pend_r
        |=> snapshot_r == '0)
        else $error("snapshot not cleared by read");
    a_snapshot_hold: assert property (!rd_accept && !load_pend_r |=> $stable(snapshot_r))
        else $error("snapshot changed without load or read");

    a_double_step: assert property (double_r && !cfg_r.shuttle && step_up && !dec_rst_r
        |=> counter_r == $past(counter_r) + COUNT_W'(1))
        else $error("double mode did not step up");
    a_double_down: assert property (double_r && !cfg_r.shuttle && step_dn && !dec_rst_r
        |=> counter_r == $past(counter_r) - COUNT_W'(1))
        else $error("double mode did not step down");
    a_common_gate: assert property (!double_r && !cfg_r.shuttle && !b_edge && !dec_rst_r
        |=> counter_r != $past(counter_r) + COUNT_W'(1))
        else $error("common mode stepped up without phase b edge");
    a_common_down: assert property (!double_r && !cfg_r.shuttle && !a_edge && !dec_rst_r
        |=> counter_r != $past(counter_r) - COUNT_W'(1))
        else $error("common mode stepped down without phase a edge");
    a_shuttle_up: assert property (cfg_r.shuttle && rise[0] && !b_edge && !dec_rst_r
        |=> counter_r == $past(counter_r) + COUNT_W'(1))
        else $error("shuttle pulse on phase a did not count up");
    a_shuttle_down: assert property (cfg_r.shuttle && rise[1] && !a_edge && !dec_rst_r
        |=> counter_r == $past(counter_r) - COUNT_W'(1))
        else $error("shuttle pulse on phase b did not count down");

    a_filter_rate: assert property (!sample_en |=> $stable(lvl))
        else $error("filtered level moved off the sample tick");
    a_slow_tick: assert property (slow_tick_r |-> slow_cnt_r == 11'h000 ##1 !slow_tick_r)
        else $error("slow tick not a single pulse");
    a_pin_select: assert property (pin_a_sel_r == 3'h0
        |-> phase_raw[0] == (pads.pa[2] ^ cfg_r.polarity))
        else $error("phase a not taken from selected pin");
    a_pin_b_select: assert property (pin_b_sel_r == 3'h7
        |-> phase_raw[1] == (pads.pd[7] ^ cfg_r.polarity))
        else $error("phase b not taken from selected pin");

    a_load_arm: assert property (wr_accept && index == `WD_IDX_LOAD
        && writedata[`WD_LOAD_BIT] |=> load_pend_r)
        else $error("load write did not arm the copy");
    a_bus_answer: assert property (req && waitrequest_r |=> !waitrequest_r ##1 waitrequest_r)
        else $error("bus answer not one cycle");
    a_wait_idle: assert property (!req |=> waitrequest_r)
        else $error("bus answered without request");
    a_write_data: assert property (write && !waitrequest_r |-> readdata_r == 32'h0000_0000)
        else $error("write answer carried read data");

    c_double_step: cover property (double_r && step_up);
    c_double_down: cover property (double_r && step_dn);
    c_common_step: cover property (!double_r && step_dn);
    c_load_then_read: cover property (load_pend_r ##[1:20] rd_accept && index == `WD_IDX_SNAPSHOT);
    c_shuttle_step: cover property (cfg_r.shuttle && step_up);

endmodule

// ===== verification/wheel_encoder_model.sv
// two-phase wheel encoder driving the port pads
// assumes the bench sets selectors and polarity to match the decoder registers
`timescale 1ns/1ps
module wheel_encoder_model
(
    input wire logic core_clk,
    input wire logic [2:0] sel_a,
    input wire logic [2:0] sel_b,
    input wire logic polarity,
    input wire logic pulse_mode,
    input wire logic step_req,
    input wire logic step_up,
    input wire logic [15:0] hold,
    output logic busy,
    output wheel_decoder_pkg::pad_bank_type pads
);
    import wheel_decoder_pkg::*;

    logic a = 1'b0;
    logic b = 1'b0;
    logic [7:0] noise = 8'h00;
    int h;

    function automatic pad_bank_type put(input pad_bank_type p, input logic [2:0] s,
                                         input logic v);
        case (s[2:1])
            2'h0: p.pa[2 + s[0]] = v;
            2'h1: p.pb[6 + s[0]] = v;
            2'h2: p.pc[2 + s[0]] = v;
            default: p.pd[6 + s[0]] = v;
        endcase
        return p;
    endfunction

    always_comb pads = put(put(pad_bank_type'({4{noise}}), sel_a, a ^ polarity), sel_b,
                           b ^ polarity);

    // unselected pins keep changing
    always @(posedge core_clk)
    begin
        noise <= noise + 8'h35;
    end

    initial
    begin
        busy <= 1'b0;
        forever
        begin
            do @(posedge core_clk); while (step_req !== 1'b1);
            h = hold;
            busy <= 1'b1;
            repeat (2)
            begin
                repeat (h) @(posedge core_clk);
                if (pulse_mode)
                begin
                    if (step_up)
                        a <= ~a;
                    else
                        b <= ~b;
                end
                else if (step_up == (a == b))
                    a <= ~a;
                else
                    b <= ~b;
            end
            repeat (h) @(posedge core_clk);
            busy <= 1'b0;
        end
    end
endmodule

// ===== verification/quadrature_wheel_decoder_tb.sv
// self-checking bench for the wheel decoder
// assumes a shortened slow tick of four core cycles
`timescale 1ns/1ps
module quadrature_wheel_decoder_tb;
    import wheel_decoder_pkg::*;

    logic core_clk = 1'b0;
    logic reset = 1'b1;
    pad_bank_type pads;
    logic [9:0] address = 10'h000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [2:0] sel_a = 3'h0;
    logic [2:0] sel_b = 3'h1;
    logic pol = 1'b0;
    logic pulse_mode = 1'b0;
    logic step_req = 1'b0;
    logic step_up = 1'b1;
    logic [15:0] hold = 16'h0028;
    logic busy;
    logic [7:0] rd;
    int num_errors = 0;
    int checks = 0;

    always #10 core_clk = ~core_clk;

    quadrature_wheel_decoder #(.SLOW_DIV(4)) DUT (.core_clk(core_clk), .reset(reset),
        .pads(pads), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest));

    wheel_encoder_model enc (.core_clk(core_clk), .sel_a(sel_a), .sel_b(sel_b),
        .polarity(pol), .pulse_mode(pulse_mode), .step_req(step_req),
        .step_up(step_up), .hold(hold), .busy(busy), .pads(pads));

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge core_clk);
        address <= {idx, 2'b00};
        writedata <= {24'h0, wd};
        read <= ~wr;
        write <= wr;
        @(posedge core_clk);
        while (waitrequest !== 1'b0)
            @(posedge core_clk);
        rd = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic snap(input string what, input logic [7:0] exp);
        bus(1'b1, 8'hd8, 8'h01);
        bus(1'b0, 8'hd0, 8'h00);
        check(what, exp, rd);
    endtask

    task automatic clr;
        bus(1'b1, 8'h60, 8'h20);
        bus(1'b1, 8'h60, 8'h00);
    endtask

    task automatic step(input logic up, input logic pm, input logic [15:0] h);
        @(posedge core_clk);
        step_up <= up;
        pulse_mode <= pm;
        hold <= h;
        step_req <= 1'b1;
        @(posedge core_clk);
        step_req <= 1'b0;
        do
            @(posedge core_clk);
        while (busy !== 1'b0);
    endtask

    task automatic t_regs;
        logic [7:0] idx [7] = '{8'hd1, 8'hd2, 8'hd3, 8'hd7, 8'hd8, 8'hd0, 8'hd6};
        logic [7:0] exp [7] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, idx[i], 8'h00);
            check("reset value", exp[i], rd);
        end
        bus(1'b1, 8'hd2, 8'hff);
        bus(1'b0, 8'hd2, 8'h00);
        check("select width", 8'h07, rd);
        bus(1'b1, 8'hd2, 8'h00);
    endtask

    task automatic t_double;
        step(1'b1, 1'b0, 16'd40);
        bus(1'b0, 8'hd0, 8'h00);
        check("no auto update", 8'h00, rd);
        snap("double step", 8'h02);
        bus(1'b0, 8'hd0, 8'h00);
        check("read clear", 8'h00, rd);
        bus(1'b0, 8'hd8, 8'h00);
        check("load self clear", 8'h00, rd);
        repeat (2) step(1'b0, 1'b0, 16'd40);
        snap("double down", 8'hfe);
    endtask

    task automatic t_common;
        bus(1'b1, 8'hd7, 8'h00);
        clr();
        snap("after reset bit", 8'h00);
        repeat (3) step(1'b1, 1'b0, 16'd40);
        snap("common up", 8'h03);
        repeat (5) step(1'b0, 1'b0, 16'd40);
        snap("common negative", 8'hfe);
    endtask

    task automatic t_pins;
        for (int k = 0; k < 8; k++)
        begin
            bus(1'b1, 8'hd2, 8'(k));
            bus(1'b1, 8'hd3, 8'((k + 3) % 8));
            bus(1'b1, 8'hd1, {3'h0, 1'(k % 2), 4'h0});
            sel_a <= 3'(k);
            sel_b <= 3'((k + 3) % 8);
            pol <= 1'(k % 2);
            repeat (60) @(posedge core_clk);
            clr();
            step(1'b1, 1'b0, 16'd40);
            snap("pin select", 8'h01);
        end
    endtask

    task automatic t_glitch;
        clr();
        step(1'b1, 1'b1, 16'd12);
        snap("short pulse", 8'h00);
        bus(1'b1, 8'hd1, 8'h11);
        step(1'b1, 1'b1, 16'd40);
        snap("scaled window", 8'h00);
        step(1'b1, 1'b0, 16'd80);
        snap("scaled step", 8'h01);
    endtask

    task automatic t_shuttle;
        bus(1'b1, 8'hd1, 8'h30);
        clr();
        repeat (2) step(1'b1, 1'b1, 16'd40);
        step(1'b0, 1'b1, 16'd40);
        snap("shuttle pulses", 8'h01);
        bus(1'b1, 8'hd7, 8'h01);
        step(1'b0, 1'b1, 16'd40);
        snap("shuttle double", 8'hff);
    endtask

    initial
    begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        wrap_up();
    end

    initial
    begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_double();
        t_common();
        t_pins();
        t_glitch();
        t_shuttle();
        wrap_up();
    end
endmodule
